// [alu_pkg.sv]
// package for the arithmetic and logic execution datapath
// assumes: one core clock, operands supplied by the decoder
package alu_pkg;

    // ------------------------------------------------------------
    // status register layout
    // ------------------------------------------------------------
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] ALL_ONES = 8'hFF;
    localparam logic [7:0] ALL_ZERO = 8'h00;
    localparam logic [7:0] ONE = 8'h01;

    // ------------------------------------------------------------
    // wishbone register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS = 8'h3F; // index of status reg
    localparam logic [9:0] ADR_STATUS = 10'h0FC; // index times four
    localparam logic [9:0] ADR_RESULT = 10'h000;
    localparam logic [9:0] ADR_COUNT = 10'h004;

    // ------------------------------------------------------------
    // operation codes
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        ALU_ADD = 5'h00,
        ALU_ADD_CARRY = 5'h01,
        ALU_SUB = 5'h02,
        ALU_SUBTRACT_BORROW = 5'h03,
        ALU_SUBTRACT_IMM = 5'h04,
        ALU_SUBTRACT_BORROW_IMM = 5'h05,
        ALU_AND = 5'h06,
        ALU_AND_IMM = 5'h07,
        ALU_OR = 5'h08,
        ALU_OR_IMM = 5'h09,
        ALU_XOR_REGISTERS = 5'h0A,
        ALU_BIT_SET_MASK = 5'h0B,
        ALU_BIT_CLEAR_MASK = 5'h0C,
        ALU_SIGN_ZERO_CHECK = 5'h0D,
        ALU_ONES_COMPLEMENT = 5'h0E,
        ALU_ARITH_INVERSE = 5'h0F,
        ALU_INCREMENT = 5'h10,
        ALU_MINUS_ONE = 5'h11,
        ALU_ZERO_REGISTER = 5'h12,
        ALU_FILL_ONES = 5'h13
    } alu_op_t;

    // request from the decoder
    typedef struct packed {
        logic valid;
        alu_op_t op;
        logic [4:0] dst_idx;
        logic [7:0] dst_val;
        logic [7:0] src_reg;
        logic [7:0] imm;
    } alu_req_t;

    // result toward the register file
    typedef struct packed {
        logic wr_en;
        logic [4:0] dst_idx;
        logic [7:0] value;
    } alu_wb_t;

endpackage : alu_pkg

// [alu_core.sv]
// combinational operation unit: result and next status flags
// assumes: caller registers outputs; status supplied from a register
`timescale 1ns/1ps
`default_nettype none
module alu_core (
    input wire alu_pkg::alu_op_t i_op,
    input wire logic [7:0] i_a,
    input wire logic [7:0] i_b,
    input wire logic [7:0] i_imm,
    input wire logic [7:0] i_status,
    output logic [7:0] o_res,
    output logic [7:0] o_status,
    output logic o_wr
);

    // ------------------------------------------------------------
    // flag helpers
    // ------------------------------------------------------------
    function automatic logic [8:0] addf(input logic [7:0] a,
        input logic [7:0] b, input logic ci);
        addf = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    endfunction : addf

    // ------------------------------------------------------------
    // operation decode
    // ------------------------------------------------------------
    always_comb begin
        logic [8:0] s;
        logic [7:0] a;
        logic [7:0] b;
        logic ci;
        logic arith;
        logic sub;
        logic zkeep;
        logic cflag;
        logic hflag;
        logic vflag;
        logic setc;
        logic nochg;
        s = 9'h000;
        a = i_a;
        b = i_b;
        ci = 1'b0;
        arith = 1'b0;
        sub = 1'b0;
        zkeep = 1'b0;
        setc = 1'b0;
        nochg = 1'b0;
        cflag = 1'b0;
        hflag = 1'b0;
        vflag = 1'b0;
        o_wr = 1'b1;
        o_res = alu_pkg::ALL_ZERO;
        unique case (i_op)
            alu_pkg::ALU_ADD, alu_pkg::ALU_ADD_CARRY: begin
                arith = 1'b1;
                ci = (i_op == alu_pkg::ALU_ADD_CARRY) &
                    i_status[alu_pkg::FLAG_C];
            end
            alu_pkg::ALU_SUB, alu_pkg::ALU_SUBTRACT_BORROW: begin
                arith = 1'b1;
                sub = 1'b1;
                zkeep = (i_op == alu_pkg::ALU_SUBTRACT_BORROW);
                ci = zkeep & i_status[alu_pkg::FLAG_C];
            end
            alu_pkg::ALU_SUBTRACT_IMM,
            alu_pkg::ALU_SUBTRACT_BORROW_IMM: begin
                arith = 1'b1;
                sub = 1'b1;
                b = i_imm;
                zkeep = (i_op == alu_pkg::ALU_SUBTRACT_BORROW_IMM);
                ci = zkeep & i_status[alu_pkg::FLAG_C];
            end
            alu_pkg::ALU_ARITH_INVERSE: begin
                arith = 1'b1;
                sub = 1'b1;
                a = alu_pkg::ALL_ZERO;
                b = i_a;
            end
            alu_pkg::ALU_INCREMENT: begin
                s = addf(i_a, alu_pkg::ONE, 1'b0);
                o_res = s[7:0];
            end
            alu_pkg::ALU_MINUS_ONE: o_res = i_a - alu_pkg::ONE;
            alu_pkg::ALU_AND: o_res = i_a & i_b;
            alu_pkg::ALU_AND_IMM: o_res = i_a & i_imm;
            alu_pkg::ALU_OR: o_res = i_a | i_b;
            alu_pkg::ALU_OR_IMM: o_res = i_a | i_imm;
            alu_pkg::ALU_XOR_REGISTERS: o_res = i_a ^ i_b;
            alu_pkg::ALU_BIT_SET_MASK: o_res = i_a | i_imm;
            alu_pkg::ALU_BIT_CLEAR_MASK:
                o_res = i_a & (alu_pkg::ALL_ONES - i_imm);
            alu_pkg::ALU_SIGN_ZERO_CHECK: o_res = i_a & i_a;
            alu_pkg::ALU_ONES_COMPLEMENT: begin
                o_res = alu_pkg::ALL_ONES - i_a;
                setc = 1'b1;
            end
            alu_pkg::ALU_ZERO_REGISTER: o_res = i_a ^ i_a;
            alu_pkg::ALU_FILL_ONES: begin
                o_res = alu_pkg::ALL_ONES;
                nochg = 1'b1;
            end
            default: o_wr = 1'b0; // illegal code: no write, no flags
        endcase
        // subtraction done as a + ~b + ~borrow, carry reads as borrow
        if (arith) begin
            if (sub) begin
                s = addf(a, ~b, ~ci);
                cflag = ~s[8];
                hflag = (~a[3] & b[3]) | (b[3] & s[3]) | (s[3] & ~a[3]);
                vflag = (a[7] & ~b[7] & ~s[7]) | (~a[7] & b[7] & s[7]);
            end else begin
                s = addf(a, b, ci);
                cflag = s[8];
                hflag = (a[3] & b[3]) | (b[3] & ~s[3]) | (~s[3] & a[3]);
                vflag = (a[7] & b[7] & ~s[7]) | (~a[7] & ~b[7] & s[7]);
            end
            o_res = s[7:0];
        end else if (i_op == alu_pkg::ALU_INCREMENT) begin
            vflag = (i_a == 8'h7F);
        end else if (i_op == alu_pkg::ALU_MINUS_ONE) begin
            vflag = (i_a == 8'h80);
        end
        o_status = i_status;
        if (o_wr && !nochg) begin
            // borrow variants keep zero set only if it already was
            o_status[alu_pkg::FLAG_Z] = (o_res == alu_pkg::ALL_ZERO) &
                (~zkeep | i_status[alu_pkg::FLAG_Z]);
            o_status[alu_pkg::FLAG_N] = o_res[7];
            o_status[alu_pkg::FLAG_V] = vflag;
            o_status[alu_pkg::FLAG_S] = o_res[7] ^ vflag;
            if (arith) begin
                o_status[alu_pkg::FLAG_C] = cflag;
                o_status[alu_pkg::FLAG_H] = hflag;
            end
            if (setc) begin
                o_status[alu_pkg::FLAG_C] = 1'b1;
            end
        end
    end

endmodule : alu_core
`default_nettype wire

// [alu_exec.sv]
// top of the arithmetic and logic execution datapath
// assumes: decoder issues at most one request per clock;
// register file writes o_wb on the following edge.
`timescale 1ns/1ps
`default_nettype none
module alu_exec (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire alu_pkg::alu_req_t i_req,
    output alu_pkg::alu_wb_t o_wb,
    output logic [7:0] o_status,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [9:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack
);

    // ------------------------------------------------------------
    // operation unit
    // ------------------------------------------------------------
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic [7:0] core_res;
    logic [7:0] core_status;
    logic core_wr;
    alu_pkg::alu_wb_t wb_q;
    alu_pkg::alu_wb_t wb_d;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic ack_q;
    logic ack_d;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic [7:0] last_q;
    logic [7:0] last_d;
    logic bus_hit;

    alu_core u_core (
        .i_op(i_req.op),
        .i_a(i_req.dst_val),
        .i_b(i_req.src_reg),
        .i_imm(i_req.imm),
        .i_status(status_q),
        .o_res(core_res),
        .o_status(core_status),
        .o_wr(core_wr)
    );

    // ------------------------------------------------------------
    // next state: status register, writeback, bus
    // ------------------------------------------------------------
    // instruction update beats a same-cycle software write so no
    // executed flag change is ever lost
    always_comb begin
        bus_hit = i_wb_cyc & i_wb_stb & ~ack_q;
        status_d = status_q;
        wb_d = '0;
        count_d = count_q;
        last_d = last_q; // result stays readable after wr_en drops
        ack_d = bus_hit;
        rdat_d = 32'h0000_0000;
        if (bus_hit && i_wb_we && i_wb_sel[0] &&
            i_wb_adr == alu_pkg::ADR_STATUS) begin
            status_d = i_wb_dat[7:0];
        end
        if (i_req.valid && core_wr) begin
            status_d = core_status; // one clock for every op
            wb_d.wr_en = 1'b1;
            wb_d.dst_idx = i_req.dst_idx;
            wb_d.value = core_res;
            last_d = core_res;
            count_d = count_q + 16'h0001;
        end
        if (bus_hit && !i_wb_we) begin
            unique case (i_wb_adr)
                alu_pkg::ADR_STATUS: rdat_d = {24'h000000, status_q};
                alu_pkg::ADR_RESULT: rdat_d = {24'h000000, last_q};
                alu_pkg::ADR_COUNT: rdat_d = {16'h0000, count_q};
                default: rdat_d = 32'h0000_0000; // unmapped reads zero
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            status_q <= alu_pkg::STATUS_RESET;
            wb_q <= '0;
            count_q <= 16'h0000;
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
            last_q <= alu_pkg::ALL_ZERO;
        end else begin
            status_q <= status_d;
            wb_q <= wb_d;
            count_q <= count_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
            last_q <= last_d;
        end
    end

    assign o_wb = wb_q;
    assign o_status = status_q;
    assign o_wb_ack = ack_q;
    assign o_wb_dat = rdat_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    add_result_a: assert property (
        i_req.valid && i_req.op == alu_pkg::ALU_ADD |=>
        o_wb.wr_en && o_wb.value ==
        8'($past(i_req.dst_val) + $past(i_req.src_reg)))
        else $error("add result wrong");
    sub_carry_a: assert property (
        i_req.valid && i_req.op == alu_pkg::ALU_SUB |=>
        o_status[alu_pkg::FLAG_C] ==
        ($past(i_req.dst_val) < $past(i_req.src_reg)))
        else $error("subtract borrow wrong");
    subimm_zero_a: assert property (
        i_req.valid && i_req.op == alu_pkg::ALU_SUBTRACT_IMM &&
        i_req.dst_val == i_req.imm |=> o_status[alu_pkg::FLAG_Z])
        else $error("immediate subtract zero wrong");
    and_keepc_a: assert property (
        i_req.valid && i_req.op == alu_pkg::ALU_AND |=>
        o_status[alu_pkg::FLAG_C] == $past(o_status[alu_pkg::FLAG_C]) &&
        !o_status[alu_pkg::FLAG_V])
        else $error("and changed carry");
    or_result_a: assert property (
        i_req.valid && i_req.op == alu_pkg::ALU_OR_IMM |=>
        o_wb.value == ($past(i_req.dst_val) | $past(i_req.imm)))
        else $error("or result wrong");
    xor_sign_a: assert property (
        i_req.valid && i_req.op == alu_pkg::ALU_XOR_REGISTERS |=>
        o_status[alu_pkg::FLAG_N] == o_wb.value[7])
        else $error("xor sign wrong");
    bitset_val_a: assert property (
        i_req.valid && i_req.op == alu_pkg::ALU_BIT_SET_MASK |=>
        (o_wb.value & $past(i_req.imm)) == $past(i_req.imm))
        else $error("bit set lost");
    bitclr_val_a: assert property (
        i_req.valid && i_req.op == alu_pkg::ALU_BIT_CLEAR_MASK |=>
        (o_wb.value & $past(i_req.imm)) == 8'h00)
        else $error("bit clear left bits");
    test_same_a: assert property (
        i_req.valid && i_req.op == alu_pkg::ALU_SIGN_ZERO_CHECK |=>
        o_wb.value == $past(i_req.dst_val))
        else $error("test altered value");
    com_carry_a: assert property (
        i_req.valid && i_req.op == alu_pkg::ALU_ONES_COMPLEMENT |=>
        o_status[alu_pkg::FLAG_C])
        else $error("complement carry not set");
    fill_flags_a: assert property (
        i_req.valid && i_req.op == alu_pkg::ALU_FILL_ONES &&
        !(i_wb_cyc && i_wb_stb && i_wb_we) |=>
        $stable(o_status) && o_wb.value == 8'hFF)
        else $error("fill ones touched flags");
    bus_ack_a: assert property (
        o_wb_ack |=> !o_wb_ack)
        else $error("ack held two cycles");
    // an illegal code must neither write nor touch the flags
    illegal_quiet_a: assert property (
        i_req.valid && i_req.op > alu_pkg::ALU_FILL_ONES && !i_wb_cyc |=>
        !o_wb.wr_en && $stable(o_status))
        else $error("illegal op had an effect");
    add_carry_a: assert property (
        i_req.valid && i_req.op == alu_pkg::ALU_ADD |=>
        o_status[alu_pkg::FLAG_C] == ((9'($past(i_req.dst_val)) +
        9'($past(i_req.src_reg))) > 9'h0FF))
        else $error("add carry wrong");
    inc_over_a: assert property (
        i_req.valid && i_req.op == alu_pkg::ALU_INCREMENT &&
        i_req.dst_val == 8'h7F |=> o_status[alu_pkg::FLAG_V])
        else $error("increment overflow missed");
    inverse_carry_a: assert property (
        i_req.valid && i_req.op == alu_pkg::ALU_ARITH_INVERSE |=>
        o_status[alu_pkg::FLAG_C] == ($past(i_req.dst_val) != 8'h00))
        else $error("arith inverse carry wrong");
    // sign is kept as n xor v by every op that touches flags
    sign_flag_a: assert property (
        i_req.valid && i_req.op < alu_pkg::ALU_FILL_ONES |=>
        o_status[alu_pkg::FLAG_S] ==
        (o_status[alu_pkg::FLAG_N] ^ o_status[alu_pkg::FLAG_V]))
        else $error("sign flag not n xor v");
    count_step_a: assert property (
        i_req.valid && i_req.op <= alu_pkg::ALU_FILL_ONES |=>
        count_q == 16'($past(count_q) + 16'h0001))
        else $error("op count did not step");
    result_keep_a: assert property (
        i_req.valid && i_req.op <= alu_pkg::ALU_FILL_ONES |=>
        last_q == o_wb.value && o_wb.dst_idx == $past(i_req.dst_idx))
        else $error("result not kept");
    // software write lands only when no op claims the same edge
    status_write_a: assert property (
        i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack && i_wb_sel[0] &&
        i_wb_adr == alu_pkg::ADR_STATUS && !i_req.valid |=>
        o_status == $past(i_wb_dat[7:0]))
        else $error("status write lost");
    ack_answer_a: assert property (
        i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("bus not answered");

    add_seen_c: cover property (i_req.valid &&
        i_req.op == alu_pkg::ALU_ADD_CARRY);
    borrow_imm_seen_c: cover property (i_req.valid &&
        i_req.op == alu_pkg::ALU_SUBTRACT_BORROW_IMM);
    inverse_seen_c: cover property (i_req.valid &&
        i_req.op == alu_pkg::ALU_ARITH_INVERSE);
    bus_seen_c: cover property (o_wb_ack);
    illegal_seen_c: cover property (i_req.valid &&
        i_req.op > alu_pkg::ALU_FILL_ONES);

endmodule : alu_exec
`default_nettype wire

// [alu_regfile_model.sv]
// working register file model that feeds the destination operand
// assumes: a result lands on the edge after o_wb shows it
`timescale 1ns/1ps
`default_nettype none
module alu_regfile_model (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire alu_pkg::alu_wb_t i_wb,
    input wire logic [4:0] i_rd_idx,
    output logic [7:0] o_rd_val
);
    logic [7:0] regs_q [32];

    // write back one edge after the result appears
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int n = 0; n < 32; n++) begin
                regs_q[n] <= 8'h00;
            end
        end else if (i_wb.wr_en) begin
            regs_q[i_wb.dst_idx] <= i_wb.value;
        end
    end

    // forward a pending result, else back-to-back ops read stale data
    assign o_rd_val = (i_wb.wr_en && i_wb.dst_idx == i_rd_idx)
        ? i_wb.value : regs_q[i_rd_idx];
endmodule : alu_regfile_model
`default_nettype wire

// [alu_arith_logic_exec_bench.sv]
// self-checking bench: integer reference model against the datapath
// assumes: the register file model supplies the destination operand
`timescale 1ns/1ps
`default_nettype none
module alu_arith_logic_exec_bench;
    logic i_sys_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic v = 1'b0;
    alu_pkg::alu_op_t op = alu_pkg::ALU_ADD;
    logic [4:0] idx = 5'h00;
    logic [7:0] src = 8'h00;
    logic [7:0] imm = 8'h00;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [9:0] adr = 10'h000;
    logic [31:0] dat = 32'h00000000;
    logic [3:0] sel = 4'h1;
    logic [3:0] lane = 4'h1;
    logic [7:0] rd_val;
    logic [31:0] rd;
    alu_pkg::alu_req_t req_w;
    alu_pkg::alu_wb_t o_wb;
    logic [7:0] o_status;
    logic [31:0] o_wb_dat;
    logic o_wb_ack;
    int fails = 0;
    int samples_checked = 0;
    int tick = 0;
    int ref_reg [32];
    int ref_st = 0;
    int ops = 0;
    int last = 0;
    int exp_q [int];
    int e;

    assign req_w = '{valid: v, op: op, dst_idx: idx, dst_val: rd_val,
                     src_reg: src, imm: imm};

    alu_exec u_alu_exec (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .i_req(req_w), .o_wb(o_wb), .o_status(o_status),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(o_wb_dat),
        .o_wb_ack(o_wb_ack));

    alu_regfile_model u_alu_regfile_model (.i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n), .i_wb(o_wb), .i_rd_idx(idx), .o_rd_val(rd_val));

    // 250 MHz clock and a free edge counter keying the expectations
    always #2 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) tick <= tick + 1;

    // ------------------------------------------------------------
    // reference model
    // ------------------------------------------------------------
    function automatic int put(input int f, input int n, input int b);
        return (f & ~(1 << n)) | ((b & 1) << n);
    endfunction : put

    // flags of ops outside the add and subtract groups keep H, and keep C except op 14, which sets it
    function automatic void ref_op(input int o, d, s, k, inout int f,
                                   output int r, output bit w);
        int c, b, t, z, ov;
        r = d;
        ov = 0;
        w = (o <= 19);
        b = (o == 4 || o == 5) ? k : s;
        c = (o == 1 || o == 3 || o == 5) ? f & 1 : 0;
        case (o)
            0, 1: begin
                t = d + s + c;
                r = t & 255;
                f = put(f, 0, t >> 8);
                f = put(f, 5, ((d & 15) + (s & 15) + c) >> 4);
                ov = ((d ^ r) & (s ^ r) & 128) != 0;
            end
            2, 3, 4, 5, 15: begin
                if (o == 15) begin
                    b = d;
                    d = 0;
                end
                r = (d - b - c) & 255;
                f = put(f, 0, d < b + c);
                f = put(f, 5, (d & 15) < (b & 15) + c);
                ov = ((d ^ b) & (d ^ r) & 128) != 0;
            end
            6: r = d & s;
            7: r = d & k;
            8: r = d | s;
            9, 11: r = d | k;
            10: r = d ^ s;
            12: r = d & (255 - k);
            14: begin
                r = 255 - d;
                f = put(f, 0, 1);
            end
            16: begin
                r = (d + 1) & 255;
                ov = (r == 128);
            end
            17: begin
                r = (d - 1) & 255;
                ov = (r == 127);
            end
            18: r = 0;
            19: r = 255;
            default: ;
        endcase
        if (o >= 19) return;
        z = (r == 0) ? ((o == 3 || o == 5) ? (f >> 1) & 1 : 1) : 0;
        f = put(f, 1, z);
        f = put(f, 2, r >> 7);
        f = put(f, 3, ov);
        f = put(f, 4, (r >> 7) ^ ov);
    endfunction : ref_op

    // ------------------------------------------------------------
    // compare and report
    // ------------------------------------------------------------
    task automatic note(input logic [31:0] g, input logic [31:0] x);
        samples_checked++;
        if (g !== x) begin
            fails++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, x);
        end
    endtask : note
    task automatic cmp_wb(input alu_pkg::alu_wb_t g, x);
        note(32'(g), 32'(x));
    endtask : cmp_wb
    task automatic cmp_st(input logic [7:0] g, x);
        note(32'(g), 32'(x));
    endtask : cmp_st
    task automatic cmp_rd(input logic [31:0] g, x);
        note(g, x);
    endtask : cmp_rd

    task automatic tally_and_finish();
        if (fails == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    // result of an op taken two ticks back; a refused code writes nothing
    always @(posedge i_sys_clk) begin
        #1;
        if (exp_q.exists(tick - 2)) begin
            e = exp_q[tick - 2];
            if (e[21]) begin
                cmp_wb(o_wb, e[21:8]);
            end else begin
                cmp_wb({o_wb.wr_en, 13'h0000}, 14'h0000);
            end
            cmp_st(o_status, e[7:0]);
        end else if (i_rst_n) begin
            cmp_wb({o_wb.wr_en, 13'h0000}, 14'h0000);
        end
    end

    // ------------------------------------------------------------
    // drivers
    // ------------------------------------------------------------
    // valid stays up so consecutive calls issue back to back
    task automatic issue(input int o, input int i, input int s, input int k);
        int r, f;
        bit w;
        @(posedge i_sys_clk);
        s = s & 255;
        k = k & 255;
        v <= 1'b1;
        op <= alu_pkg::alu_op_t'(o[4:0]);
        idx <= i[4:0];
        src <= s[7:0];
        imm <= k[7:0];
        f = ref_st;
        ref_op(o, ref_reg[i], s, k, f, r, w);
        ref_st = f;
        if (w) begin
            ref_reg[i] = r;
            ops++;
            last = r;
        end
        exp_q[tick] = (int'(w) << 21) | (i << 16) | ((r & 255) << 8) | f;
    endtask : issue

    task automatic wb(input logic w, input logic [9:0] a,
                      input logic [7:0] dw);
        int n;
        @(posedge i_sys_clk);
        v <= 1'b0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= lane;
        adr <= a;
        dat <= {24'h000000, dw};
        for (n = 0; n < 20; n++) begin
            @(posedge i_sys_clk);
            if (o_wb_ack === 1'b1) break;
        end
        if (n == 20) begin
            fails++;
            tally_and_finish();
        end
        rd = o_wb_dat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    // main sequence
    initial begin
        void'($urandom(20));
        repeat (2) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        @(posedge i_sys_clk);
        #1;
        cmp_st(o_status, 8'h00);
        for (int i = 0; i < 32; i++) issue(0, i, $urandom, 0);
        for (int n = 0; n < 400; n++) begin
            issue($urandom_range(19, 0), $urandom_range(31, 0),
                  $urandom, $urandom);
        end
        issue(19, 1, 0, 0);
        issue(16, 1, 0, 0);
        issue(18, 2, 0, 0);
        issue(0, 2, 8'h7F, 0);
        issue(16, 2, 0, 0);
        issue(17, 2, 0, 0);
        issue(15, 2, 0, 0);
        for (int o = 20; o < 32; o++) issue(o, 3, 1, 1);
        wb(1'b1, alu_pkg::ADR_STATUS, 8'hC1);
        ref_st = 8'hC1;
        wb(1'b0, alu_pkg::ADR_STATUS, 8'h00);
        cmp_rd(rd, 32'h000000C1);
        issue(1, 4, 1, 0);
        issue(5, 4, 0, 0);
        wb(1'b1, 10'h010, 8'hFF);
        // a write without lane 0 must leave the flags alone
        lane = 4'h0;
        wb(1'b1, alu_pkg::ADR_STATUS, 8'h3C);
        lane = 4'h1;
        wb(1'b0, alu_pkg::ADR_STATUS, 8'h00);
        cmp_rd(rd, 32'(ref_st));
        wb(1'b0, alu_pkg::ADR_RESULT, 8'h00);
        cmp_rd(rd, 32'(last));
        wb(1'b0, alu_pkg::ADR_COUNT, 8'h00);
        cmp_rd(rd, 32'(ops));
        wb(1'b0, 10'h008, 8'h00);
        cmp_rd(rd, 32'h00000000);
        repeat (3) @(posedge i_sys_clk);
        tally_and_finish();
    end
endmodule : alu_arith_logic_exec_bench
`default_nettype wire
